// >>> core/sbd_pkg.sv
// Constants and carrier types for the single-wire background debug link
package sbd_pkg;
  localparam int BIT_CYC = 16;
  localparam int SAMPLE_CYC = 10;
  localparam int SPEEDUP_CYC = 7;
  localparam int ZERO_LOW_CYC = 13;
  localparam int TIMEOUT_CYC = 512;
  localparam int CNT_W = 10;
  localparam logic [7:0] CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_TRACE = 8'h10;
  localparam logic [7:0] CMD_TAGGO = 8'h18;
  localparam logic [7:0] CMD_STATUS = 8'hE4;
  localparam logic [7:0] CMD_CONTROL = 8'hC4;
  localparam logic [7:0] CMD_RD_BKPT = 8'hE2;
  localparam logic [7:0] CMD_WR_BKPT = 8'hC2;
  localparam int CTL_CLKSEL = 2;
  localparam int CTL_ALLOW = 7;
  localparam int CTL_BKPT_EN = 6;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_RX, ST_TX, ST_DONE
  } sbd_state_type;

  // Pin drive pair: out value and active-low enable
  typedef struct packed {
    logic out;
    logic oe_b;
  } sbd_pin_type;

  // Requests made toward the CPU and system
  typedef struct packed {
    logic halt_req;
    logic go_req;
    logic trace_req;
    logic wake_req;
  } sbd_cpu_type;
endpackage : sbd_pkg

// >>> core/sbd_sync.sv
// Two-flop synchroniser with falling-edge detect behind it
`timescale 1ns/1ps
module sbd_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic din,
  output logic level,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sbd_sync_state_type;
  sbd_sync_state_type st_ff;
  sbd_sync_state_type nxt_st;

  // Only s2 and s3 feed logic; s1 feeds s2, and feeds s3 as well during reset
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // Keeps sampling through reset so the strap level is settled at release;
  // s3 follows s1 so no false edge appears when reset lifts
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff <= {din, st_ff.s1, st_ff.s1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.s2;
  assign fall = st_ff.s3 & ~st_ff.s2;
endmodule : sbd_sync

// >>> core/sbd_clkdiv.sv
// Debug clock enable: bus rate or divided alternate rate
`timescale 1ns/1ps
module sbd_clkdiv (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sel_alt,
  output logic tick
);
  localparam logic [1:0] ALT_DIV = 2'h3;
  typedef struct packed {
    logic [1:0] cnt;
  } sbd_div_state_type;
  sbd_div_state_type st_ff;
  sbd_div_state_type nxt_st;

  // Alternate source modelled as core rate divided by four
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt = (st_ff.cnt == ALT_DIV) ? 2'h0 : st_ff.cnt + 2'h1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = sel_alt ? (st_ff.cnt == ALT_DIV) : 1'b1;
endmodule : sbd_clkdiv

// >>> core/sbd_link.sv
// Single-wire background debug controller: bit engine and command front end
`timescale 1ns/1ps
module sbd_link (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic por_flag,
  input wire logic force_background_flag,
  input wire logic debug_pin_in,
  output logic debug_pin_out,
  output logic debug_pin_oe_b,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_halted,
  input wire logic cpu_stopped,
  output sbd_pkg::sbd_cpu_type cpu_req,
  output logic bkpt_hit,
  output logic osc_keep,
  output logic watchdog_hold,
  output logic boot_background,
  output logic [7:0] cmd_code,
  output logic cmd_valid
);
  import sbd_pkg::*;

  typedef struct packed {
    sbd_state_type st;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] gap_cnt;
    logic in_bit;
    logic [4:0] nbits;
    logic [15:0] shreg;
    logic [7:0] cmd;
    logic [7:0] ctl;
    logic [15:0] bkpt;
    logic tx_bit;
    logic pin_out;
    logic pin_oe_b;
    logic boot_done;
    logic boot_bg;
    logic halt_req;
    logic go_req;
    logic trace_req;
    logic wake_req;
    logic cmd_valid;
    logic hit;
  } sbd_link_state_type;

  sbd_link_state_type st_ff;
  sbd_link_state_type nxt_st;
  logic pin_lvl;
  logic pin_fall;
  logic dtick;

  // Active-mode codes need the CPU halted
  function automatic logic needs_halt(input logic [7:0] c);
    needs_halt = (c[7:6] == 2'b00) || (c[7:5] == 3'b010) || (c[7:4] == 4'h6)
                 || (c[7:4] == 4'h7);
  endfunction : needs_halt

  // Number of reply bits a known command sends back
  function automatic logic [4:0] tx_len(input logic [7:0] c);
    case (c)
      CMD_STATUS: tx_len = 5'd8;
      CMD_RD_BKPT: tx_len = 5'd16;
      default: tx_len = 5'd0;
    endcase
  endfunction : tx_len

  // Number of data bits a known command receives
  function automatic logic [4:0] rx_len(input logic [7:0] c);
    case (c)
      CMD_CONTROL: rx_len = 5'd8;
      CMD_WR_BKPT: rx_len = 5'd16;
      default: rx_len = 5'd0;
    endcase
  endfunction : rx_len

  // Pin goes through two flops before anything reads it
  sbd_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .din(debug_pin_in),
    .level(pin_lvl),
    .fall(pin_fall)
  );

  sbd_clkdiv u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sel_alt(st_ff.ctl[CTL_CLKSEL]),
    .tick(dtick)
  );

  // Bit engine and command decode
  always_comb begin
    nxt_st = st_ff;
    nxt_st.go_req = 1'b0;
    nxt_st.trace_req = 1'b0;
    nxt_st.wake_req = 1'b0;
    nxt_st.cmd_valid = 1'b0;
    // Mode strap caught one cycle after reset release, from synced pin
    if (!st_ff.boot_done) begin
      nxt_st.boot_done = 1'b1;
      nxt_st.boot_bg = por_flag & ~pin_lvl;
      nxt_st.halt_req = por_flag & ~pin_lvl;
    end
    // Forced entry after a live force-flag write
    if (force_background_flag && !pin_lvl) begin
      nxt_st.halt_req = 1'b1;
    end
    if (!cpu_halted && st_ff.halt_req && st_ff.boot_done && nxt_st.halt_req == st_ff.halt_req) begin
      nxt_st.halt_req = st_ff.halt_req;
    end
    if (cpu_halted) begin
      nxt_st.halt_req = 1'b0;
    end
    // Breakpoint compare on CPU address
    nxt_st.hit = st_ff.ctl[CTL_BKPT_EN] && (cpu_addr == st_ff.bkpt);
    // Gap counter restarted by each falling edge on the pin
    if (pin_fall) begin
      nxt_st.gap_cnt = '0;
    end else if (dtick && st_ff.gap_cnt != CNT_W'(TIMEOUT_CYC)) begin
      nxt_st.gap_cnt = st_ff.gap_cnt + 1'b1;
    end
    if (dtick && st_ff.gap_cnt == CNT_W'(TIMEOUT_CYC - 1) && st_ff.st != ST_IDLE) begin
      nxt_st.st = ST_IDLE;
      nxt_st.in_bit = 1'b0;
      nxt_st.pin_oe_b = 1'b1;
    end else if (pin_fall && !st_ff.in_bit) begin
      nxt_st.in_bit = 1'b1;
      nxt_st.bit_cnt = '0;
      if (st_ff.st == ST_IDLE) begin
        nxt_st.st = ST_CMD;
        nxt_st.nbits = 5'd8;
      end
      if (st_ff.st == ST_TX) begin
        nxt_st.tx_bit = st_ff.shreg[15];
        nxt_st.shreg = {st_ff.shreg[14:0], 1'b0};
      end
    end else if (st_ff.in_bit && dtick) begin
      nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
      if (st_ff.st == ST_TX) begin
        if (st_ff.bit_cnt == '0 && !st_ff.tx_bit) begin
          nxt_st.pin_out = 1'b0;
          nxt_st.pin_oe_b = 1'b0;
        end
        if (st_ff.bit_cnt == CNT_W'(SPEEDUP_CYC - 1) && st_ff.tx_bit) begin
          nxt_st.pin_out = 1'b1;
          nxt_st.pin_oe_b = 1'b0;
        end else if (st_ff.bit_cnt == CNT_W'(ZERO_LOW_CYC - 1) && !st_ff.tx_bit) begin
          nxt_st.pin_out = 1'b1;
          nxt_st.pin_oe_b = 1'b0;
        end else if (!st_ff.pin_oe_b && st_ff.pin_out) begin
          nxt_st.pin_oe_b = 1'b1;
        end
      end else if (st_ff.bit_cnt == CNT_W'(SAMPLE_CYC - 1)) begin
        nxt_st.shreg = {st_ff.shreg[14:0], pin_lvl};
        nxt_st.nbits = st_ff.nbits - 1'b1;
      end
      if (st_ff.bit_cnt == CNT_W'(BIT_CYC - 1)) begin
        nxt_st.in_bit = 1'b0;
        nxt_st.pin_oe_b = 1'b1;
        if (st_ff.st == ST_TX) begin
          nxt_st.nbits = st_ff.nbits - 1'b1;
          if (st_ff.nbits == 5'd1) begin
            nxt_st.st = ST_IDLE;
          end
        end else if (st_ff.nbits == '0) begin
          if (st_ff.st == ST_CMD) begin
            nxt_st.cmd = st_ff.shreg[7:0];
            nxt_st.cmd_valid = 1'b1;
            nxt_st.st = ST_IDLE;
            if (needs_halt(st_ff.shreg[7:0]) && !cpu_halted) begin
              nxt_st.st = ST_IDLE;
              nxt_st.cmd_valid = 1'b0;
            end else if (st_ff.shreg[7:0] == CMD_BACKGROUND) begin
              if (st_ff.ctl[CTL_ALLOW]) begin
                nxt_st.halt_req = 1'b1;
                nxt_st.wake_req = cpu_stopped;
              end
            end else if (st_ff.shreg[7:0] == CMD_GO || st_ff.shreg[7:0] == CMD_TAGGO) begin
              nxt_st.go_req = 1'b1;
            end else if (st_ff.shreg[7:0] == CMD_TRACE) begin
              nxt_st.trace_req = 1'b1;
            end else if (tx_len(st_ff.shreg[7:0]) != '0) begin
              nxt_st.st = ST_TX;
              nxt_st.nbits = tx_len(st_ff.shreg[7:0]);
              nxt_st.shreg = (st_ff.shreg[7:0] == CMD_STATUS)
                             ? {st_ff.ctl | {7'h00, cpu_halted}, 8'h00} : st_ff.bkpt;
            end else if (rx_len(st_ff.shreg[7:0]) != '0) begin
              nxt_st.st = ST_RX;
              nxt_st.nbits = rx_len(st_ff.shreg[7:0]);
            end
          end else if (st_ff.st == ST_RX) begin
            if (st_ff.cmd == CMD_CONTROL) begin
              nxt_st.ctl = st_ff.shreg[7:0];
            end else begin
              nxt_st.bkpt = st_ff.shreg;
            end
            nxt_st.st = ST_IDLE;
          end
        end
      end
    end
  end

  // Synchronous active-low reset to released pin and idle engine
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.st <= ST_IDLE;
      st_ff.pin_out <= 1'b1;
      st_ff.pin_oe_b <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign debug_pin_out = st_ff.pin_out;
  assign debug_pin_oe_b = st_ff.pin_oe_b;
  assign cpu_req = '{halt_req: st_ff.halt_req, go_req: st_ff.go_req,
                     trace_req: st_ff.trace_req, wake_req: st_ff.wake_req};
  assign bkpt_hit = st_ff.hit;
  assign osc_keep = st_ff.ctl[CTL_ALLOW];
  assign watchdog_hold = cpu_halted;
  assign boot_background = st_ff.boot_bg;
  assign cmd_code = st_ff.cmd;
  assign cmd_valid = st_ff.cmd_valid;

  // Pin released while receiving host bits
  AST_RX_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.st == ST_RX || st_ff.st == ST_CMD) |-> st_ff.pin_oe_b)
    else $error("pin driven during host bit");

  // Gap reaching the limit returns the engine to idle
  AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dtick && st_ff.gap_cnt == CNT_W'(TIMEOUT_CYC - 1) && !pin_fall) |=> st_ff.st == ST_IDLE)
    else $error("timeout did not abort");

  // Low drive only ever when sending
  AST_LOW_IN_TX: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!st_ff.pin_oe_b && !st_ff.pin_out) |-> st_ff.st == ST_TX || $past(st_ff.st) == ST_TX)
    else $error("low drive outside reply");

  // Speedup pulse lasts exactly one debug tick when bus clock selected
  AST_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!st_ff.ctl[CTL_CLKSEL] && $fell(st_ff.pin_oe_b) && st_ff.pin_out && st_ff.st == ST_TX)
    |=> st_ff.pin_oe_b)
    else $error("speedup pulse too long");

  // Background raises no wake request when not allowed
  AST_ALLOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.cmd_valid && st_ff.cmd == CMD_BACKGROUND && !st_ff.ctl[CTL_ALLOW]) |-> !st_ff.wake_req)
    else $error("background accepted while barred");

  // Active-mode command never valid while running
  AST_HALT_ONLY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.go_req || st_ff.trace_req) |-> $past(cpu_halted))
    else $error("active command while running");

  // Command byte is eight sampled bits
  AST_CMD_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(st_ff.cmd_valid) |-> st_ff.cmd == $past(st_ff.shreg[7:0]))
    else $error("command byte mismatch");

  // Watchdog held throughout halt
  AST_WDOG: assert property (@(posedge core_clk) disable iff (!rst_b)
    cpu_halted |-> watchdog_hold)
    else $error("watchdog not held");
endmodule : sbd_link

// >>> verif/sbd_host.sv
// Host pod model: opens every bit time on the debug pin and reads replies
`timescale 1ns/1ps
module sbd_host (
  input wire logic core_clk,
  input wire logic pin,
  output logic drv_oe_b,
  output logic drv_out
);
  int sc = 1;
  int gap = 0;
  logic tx_busy = 1'b0;

  initial begin
    drv_oe_b = 1'b1;
    drv_out = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // Ones go high early; the host drives high itself for a fast rise
  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge core_clk);
      tx_busy <= 1'b1;
      drv_oe_b <= 1'b0;
      drv_out <= 1'b0;
      wait_cyc(v[i] ? 4 * sc : 14 * sc);
      drv_out <= 1'b1;
      wait_cyc(v[i] ? 12 * sc + 8 : 2 * sc + 8);
      drv_oe_b <= 1'b1;
      tx_busy <= 1'b0;
      wait_cyc(gap);
    end
  endtask : send_bits

  // Short low then release, well before the target speedup pulse
  task automatic recv_bits(output logic [15:0] v, input int n);
    v = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge core_clk);
      drv_oe_b <= 1'b0;
      drv_out <= 1'b0;
      wait_cyc(2 * sc);
      drv_oe_b <= 1'b1;
      wait_cyc(8 * sc);
      v[i] = pin;
      wait_cyc(6 * sc + 8 + gap);
    end
  endtask : recv_bits
endmodule : sbd_host

// >>> verif/tb_sbd_link.sv
// Self-checking bench for the debug link against a host pod model
`timescale 1ns/1ps
module tb_sbd_link;
  import sbd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_flag = 1'b1;
  logic force_background_flag = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_halted = 1'b0;
  logic cpu_stopped = 1'b0;
  logic debug_pin_out, debug_pin_oe_b, h_oe_b, h_out, debug_pin;
  sbd_cpu_type cpu_req;
  logic bkpt_hit, osc_keep, watchdog_hold, boot_background, cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] ctl = 8'h00;
  logic [7:0] exp_q[$];
  logic [15:0] rd, bp;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 2396;
  int go_n = 0, trace_n = 0, wake_n = 0;

  always #50 core_clk = ~core_clk;

  // Pullup wins only when nobody drives
  assign debug_pin = (debug_pin_oe_b == 1'b0) ? debug_pin_out : ((h_oe_b == 1'b0) ? h_out : 1'b1);

  sbd_link dut (.core_clk(core_clk), .rst_b(rst_b), .por_flag(por_flag),
    .force_background_flag(force_background_flag), .debug_pin_in(debug_pin),
    .debug_pin_out(debug_pin_out), .debug_pin_oe_b(debug_pin_oe_b), .cpu_addr(cpu_addr),
    .cpu_halted(cpu_halted), .cpu_stopped(cpu_stopped), .cpu_req(cpu_req),
    .bkpt_hit(bkpt_hit), .osc_keep(osc_keep), .watchdog_hold(watchdog_hold),
    .boot_background(boot_background), .cmd_code(cmd_code), .cmd_valid(cmd_valid));
  sbd_host h (.core_clk(core_clk), .pin(debug_pin), .drv_oe_b(h_oe_b), .drv_out(h_out));

  task automatic chk_data(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data

  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Watchdog on the run, command stream against the model queue, pulse counts
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
    if (rst_b === 1'b1 && cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_flag("cmd_valid", 1'b0, cmd_valid);
      else chk_data("cmd_code", {8'h00, exp_q.pop_front()}, {8'h00, cmd_code});
    end
    if (cpu_req.go_req === 1'b1) go_n++;
    if (cpu_req.trace_req === 1'b1) trace_n++;
    if (cpu_req.wake_req === 1'b1) wake_n++;
    if (h.tx_busy === 1'b1) chk_flag("pin_release", 1'b1, debug_pin_oe_b);
  end

  // Strap level held through reset, released one cycle after
  task automatic do_reset(input logic por, input logic low, input logic e);
    rst_b <= 1'b0;
    por_flag <= por;
    h.drv_oe_b <= ~low;
    h.drv_out <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    h.drv_oe_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_flag("boot_background", e, boot_background);
    repeat (600) @(posedge core_clk);
  endtask : do_reset

  // Refused codes push nothing, so any echo shows up as a stray pulse
  task automatic cmd(input logic [7:0] c, input logic ok, input logic dly);
    if (ok) exp_q.push_back(c);
    h.send_bits({8'h00, c}, 8);
    if (dly) h.wait_cyc(16 * h.sc + 8);
  endtask : cmd

  task automatic wr_ctl(input logic [7:0] c);
    cmd(CMD_CONTROL, 1'b1, 1'b0);
    h.send_bits({8'h00, c}, 8);
    ctl = c;
  endtask : wr_ctl

  task automatic rd_status();
    cmd(CMD_STATUS, 1'b1, 1'b0);
    h.recv_bits(rd, 8);
    chk_data("status", {8'h00, ctl | {7'h00, cpu_halted}}, rd);
  endtask : rd_status

  initial begin
    cpu_stopped <= 1'($random(seed));
    do_reset(1'b1, 1'b1, 1'b1);
    do_reset(1'b0, 1'b1, 1'b0);
    do_reset(1'b1, 1'b0, 1'b0);
    wr_ctl(8'h00);
    rd_status();
    cmd(CMD_GO, 1'b0, 1'b1);
    chk_data("go_count", 16'h0000, 16'(go_n));
    cmd(CMD_BACKGROUND, 1'b1, 1'b1);
    chk_flag("halt_req", 1'b0, cpu_req.halt_req);
    wr_ctl(8'h80);
    chk_flag("osc_keep", 1'b1, osc_keep);
    cpu_stopped <= 1'b1;
    cmd(CMD_BACKGROUND, 1'b1, 1'b1);
    chk_flag("halt_req", 1'b1, cpu_req.halt_req);
    chk_data("wake_count", 16'h0001, 16'(wake_n));
    cpu_halted <= 1'b1;
    cpu_stopped <= 1'b0;
    h.wait_cyc(3);
    chk_flag("watchdog_hold", 1'b1, watchdog_hold);
    rd_status();
    foreach (exp_q[i]) chk_flag("queue_idle", 1'b0, 1'b1);
    cmd(CMD_GO, 1'b1, 1'b1);
    cmd(CMD_TRACE, 1'b1, 1'b1);
    cmd(CMD_TAGGO, 1'b1, 1'b1);
    chk_data("go_count", 16'h0002, 16'(go_n));
    chk_data("trace_count", 16'h0001, 16'(trace_n));
    // Slow pacing from the pod while the breakpoint goes in and out
    h.gap = 40;
    bp = 16'($random(seed));
    cmd(CMD_WR_BKPT, 1'b1, 1'b0);
    h.send_bits(bp, 16);
    cmd(CMD_RD_BKPT, 1'b1, 1'b0);
    h.recv_bits(rd, 16);
    chk_data("bkpt", bp, rd);
    h.gap = 0;
    wr_ctl(8'hC0);
    cpu_addr <= bp;
    h.wait_cyc(3);
    chk_flag("bkpt_hit", 1'b1, bkpt_hit);
    cpu_addr <= bp ^ 16'h0001;
    h.wait_cyc(3);
    chk_flag("bkpt_hit", 1'b0, bkpt_hit);
    // Half a command, then silence past the abort limit
    h.send_bits(16'h000E, 4);
    h.wait_cyc(600);
    rd_status();
    wr_ctl(8'hC4);
    h.sc = 4;
    rd_status();
    wr_ctl(8'hC0);
    h.sc = 1;
    // Force flag with the pin pulled low straight after a command
    cpu_halted <= 1'b0;
    force_background_flag <= 1'b1;
    h.drv_oe_b <= 1'b0;
    h.drv_out <= 1'b0;
    h.wait_cyc(200);
    chk_flag("halt_req", 1'b1, cpu_req.halt_req);
    h.drv_oe_b <= 1'b1;
    force_background_flag <= 1'b0;
    h.wait_cyc(600);
    chk_data("pending_cmds", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : tb_sbd_link
